//--- logic/wdt_regs.vh
// constants for the watchdog timer block
// assumes a single 10 MHz core clock and active-high asynchronous reset
`ifndef WDT_REGS_VH
`define WDT_REGS_VH
`define WDT_CNT_W 12
`define WDT_CNT_MSB 11
`define WDT_RELOAD 12'hFFF
`define WDT_ADDR_CNT 8'h60
`define WDT_ADDR_FSEL 8'h61
`define WDT_ADDR_PMODE 8'h5E
`define WDT_SWRST_BIT 3
`define WDT_PRE_W 9
`define WDT_FAST_DIV 9'h01F
`define WDT_SLOW_DIV 9'h1FF
`define WDT_RSTPULSE_CYC 4'h4
`endif

//--- logic/wdt_prescaler.v
// free-running prescaler giving divide-by-32 and divide-by-512 tick pulses
// assumes one clock; ticks are one-cycle enables
`include "wdt_regs.vh"
module wdt_prescaler (
   input wire core_clk, // system clock
   input wire rst, // async reset, active high
   input wire restart, // realign prescaler
   output reg fastPrescaleTick, // one pulse per 32 clocks
   output reg slowPrescaleTick // one pulse per 512 clocks
);
   reg [`WDT_PRE_W-1:0] div_r;
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         div_r <= {`WDT_PRE_W{1'b0}};
         fastPrescaleTick <= 1'b0;
         slowPrescaleTick <= 1'b0;
      end
      else
      begin
         div_r <= restart ? {`WDT_PRE_W{1'b0}} : div_r + 9'h001; // RQ10
         fastPrescaleTick <= ~restart & ((div_r & `WDT_FAST_DIV) == `WDT_FAST_DIV); // RQ10
         slowPrescaleTick <= ~restart & (div_r == `WDT_SLOW_DIV); // RQ10
      end
   end
endmodule

//--- logic/wdt_timer.v
// watchdog timer: 12-bit down-counter, frequency select flag, software reset pulse
// assumes write strobes from the cpu bus decoder are one-cycle pulses synchronous to core_clk
//
// Operation
// RQ1: watchdog is one 12-bit down-counter; its top bit signals expiry.
// RQ2: flag 0 counts clock/512, flag 1 counts clock/32; reset clears flag.
// RQ3: counter loads FFF on reset, stop-clock, any write, or top bit zero; the code reloads only on writes to address 60.
// RQ4: each selected tick decrements; top bit zero sets interrupt request, reloads.
// RQ5: overvoltage indication on reset pin stops the watchdog entirely.
// RQ6: counter holds during bus hold, DMA transfer or DRAM refresh.
// RQ7: writing one to processor mode bit 3 yields a processor reset pulse.
// RQ8: software must rewrite the counter before its top bit clears.
// RQ9: frequency select flag lives at address 61, after the counter at 60.
// RQ10: both ticks are one-cycle enables from one free-running prescaler.
`include "wdt_regs.vh"
module wdt_timer (
   input wire core_clk, // 10 MHz system clock
   input wire rst, // async chip reset, active high
   input wire wrStrobe, // one-cycle register write strobe
   input wire [7:0] wrAddr, // register write address
   input wire [7:0] wrData, // register write data
   input wire stopClockInstruction, // pulse: stop-clock instruction executed
   input wire resetOvervoltage, // reset pin held at double supply
   input wire busHoldGranted, // bus hold in progress
   input wire dmaActive, // dma transfer in progress
   input wire refreshActive, // dram refresh cycle running
   input wire irqAck, // pulse: cpu clears interrupt request
   output reg [11:0] wdtCount, // current counter value
   output reg freqSelect, // frequency select flag
   output reg wdtIrqReq, // watchdog interrupt request bit
   output reg swResetPulse // processor reset pulse
);
   localparam [0:0] SR_IDLE = 1'b0;
   localparam [0:0] SR_PULSE = 1'b1;

   wire fastPrescaleTick;
   wire slowPrescaleTick;
   wire selTick;
   wire holdReq;
   wire cntWrite;
   wire fselWrite;
   wire swrstWrite;
   wire reloadReq;
   wire expire;
   wire decEn;
   wire [`WDT_CNT_W-1:0] borrow;
   wire [`WDT_CNT_W-1:0] decValue;
   reg [`WDT_CNT_W-1:0] count_nxt;
   reg freqSel_nxt;
   reg irqReq_nxt;
   reg srState_r;
   reg srState_nxt;
   reg [3:0] pulseCnt_r;
   reg [3:0] pulseCnt_nxt;
   reg swPulse_nxt;
   genvar i;

   // strobe qualified address match, shared by all three write targets
   function regHit;
      input strobe;
      input [7:0] addr;
      input [7:0] target;
      begin
         regHit = strobe & (addr == target);
      end
   endfunction

   wdt_prescaler prescaler (
      .core_clk(core_clk),
      .rst(rst),
      .restart(resetOvervoltage), // RQ5 RQ10
      .fastPrescaleTick(fastPrescaleTick),
      .slowPrescaleTick(slowPrescaleTick)
   );

   assign cntWrite = regHit(wrStrobe, wrAddr, `WDT_ADDR_CNT); // RQ3
   assign fselWrite = regHit(wrStrobe, wrAddr, `WDT_ADDR_FSEL); // RQ9
   assign swrstWrite = regHit(wrStrobe, wrAddr, `WDT_ADDR_PMODE) & wrData[`WDT_SWRST_BIT]; // RQ7
   assign selTick = freqSelect ? fastPrescaleTick : slowPrescaleTick; // RQ2
   assign holdReq = busHoldGranted | dmaActive | refreshActive; // RQ6
   assign expire = ~wdtCount[`WDT_CNT_MSB]; // RQ1
   assign reloadReq = stopClockInstruction | cntWrite | expire; // RQ3
   // ticks that land during hold are dropped, not deferred
   assign decEn = selTick & ~holdReq; // RQ4 RQ6

   // ripple borrow chain for the one-step decrement
   assign borrow[0] = 1'b1;
   generate
      for (i = 0; i < `WDT_CNT_W; i = i + 1)
      begin : g_dec
         assign decValue[i] = wdtCount[i] ^ borrow[i]; // RQ4
         if (i > 0)
         begin : g_borrow
            assign borrow[i] = borrow[i - 1] & ~wdtCount[i - 1];
         end
      end
   endgenerate

   // overvoltage outranks every reload, a reload outranks a tick
   always @*
   begin
      count_nxt = wdtCount;
      if (resetOvervoltage)
      begin
         count_nxt = `WDT_RELOAD; // RQ5
      end
      else if (reloadReq)
      begin
         count_nxt = `WDT_RELOAD; // RQ3 RQ4
      end
      else if (decEn)
      begin
         count_nxt = decValue; // RQ4 RQ6
      end
   end

   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         wdtCount <= `WDT_RELOAD; // RQ3
      end
      else
      begin
         wdtCount <= count_nxt;
      end
   end

   always @*
   begin
      freqSel_nxt = freqSelect;
      if (fselWrite)
      begin
         freqSel_nxt = wrData[0]; // RQ9
      end
   end

   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         freqSelect <= 1'b0; // RQ2
      end
      else
      begin
         freqSelect <= freqSel_nxt;
      end
   end

   // set wins over acknowledge when both fall in one cycle
   always @*
   begin
      irqReq_nxt = wdtIrqReq;
      if (expire & ~resetOvervoltage)
      begin
         irqReq_nxt = 1'b1; // RQ4
      end
      else if (irqAck)
      begin
         irqReq_nxt = 1'b0;
      end
   end

   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         wdtIrqReq <= 1'b0;
      end
      else
      begin
         wdtIrqReq <= irqReq_nxt;
      end
   end

   // reset pulse: a fresh write restarts the pulse from its full length
   always @*
   begin
      srState_nxt = srState_r;
      pulseCnt_nxt = pulseCnt_r;
      swPulse_nxt = 1'b0;
      case (srState_r)
         SR_IDLE:
         begin
            if (swrstWrite)
            begin
               srState_nxt = SR_PULSE;
               pulseCnt_nxt = `WDT_RSTPULSE_CYC - 4'h1;
               swPulse_nxt = 1'b1; // RQ7
            end
         end
         SR_PULSE:
         begin
            if (swrstWrite)
            begin
               pulseCnt_nxt = `WDT_RSTPULSE_CYC - 4'h1;
               swPulse_nxt = 1'b1; // RQ7
            end
            else if (pulseCnt_r != 4'h0)
            begin
               pulseCnt_nxt = pulseCnt_r - 4'h1;
               swPulse_nxt = 1'b1; // RQ7
            end
            else
            begin
               srState_nxt = SR_IDLE;
            end
         end
         default:
         begin
            srState_nxt = SR_IDLE;
            pulseCnt_nxt = 4'h0;
         end
      endcase
   end

   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         srState_r <= SR_IDLE;
         pulseCnt_r <= 4'h0;
         swResetPulse <= 1'b0;
      end
      else
      begin
         srState_r <= srState_nxt;
         pulseCnt_r <= pulseCnt_nxt;
         swResetPulse <= swPulse_nxt;
      end
   end
endmodule

//--- tb/wdt_timer_assertions.sv
// port checks for wdt_timer
// one clock, async high rst
module wdt_timer_assertions(input wire logic core_clk,rst,wrStrobe,resetOvervoltage,wdtIrqReq,swResetPulse,
 input wire logic busHoldGranted,dmaActive,refreshActive,stopClockInstruction,
 input wire logic [7:0] wrAddr,wrData,input wire logic [11:0] wdtCount);
   timeunit 1ns; timeprecision 1ns;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence pulse4; swResetPulse[*4] ##1 !swResetPulse; endsequence
   a_wr_reload: assert property (wrStrobe&&wrAddr==8'h60|=>wdtCount==12'hFFF) else $error("reload");
   a_expiry_irq:
   assert property (!wdtCount[11]&&!resetOvervoltage|=>wdtIrqReq&&wdtCount==12'hFFF) else $error("irq");
   a_one_step:
   assert property (!$stable(wdtCount)&&wdtCount!=12'hFFF|->wdtCount==$past(wdtCount)-12'h1) else $error("dec");
   a_swrst_pulse: assert property (wrStrobe&&wrAddr==8'h5E&&wrData[3]|=>pulse4) else $error("swrst");
   a_stop_reload: assert property (stopClockInstruction|=>wdtCount==12'hFFF) else $error("stop");
   a_overvolt_stop:
   assert property (resetOvervoltage|=>wdtCount==12'hFFF&&!$rose(wdtIrqReq)) else $error("ovv");
   a_hold_freeze:
   assert property ((busHoldGranted||dmaActive||refreshActive)&&!resetOvervoltage&&!stopClockInstruction
    &&!(wrStrobe&&wrAddr==8'h60)&&wdtCount[11]|=>$stable(wdtCount)) else $error("hold");
endmodule
bind wdt_timer wdt_timer_assertions chk(.*);

//--- tb/wdt_cpu_model.sv
// cpu side: acks the irq
// irq holds until acked
module wdt_cpu_model(input wire logic core_clk,rst,irq,output logic ack);
   timeunit 1ns; timeprecision 1ns;
   always @(posedge core_clk or posedge rst) ack<=rst ? 1'b0 : irq&&!ack;
endmodule

//--- tb/wdt_timer_test.sv
// bench for wdt_timer
// cpu model acks the irq
module wdt_timer_test;
   timeunit 1ns; timeprecision 1ns;
   logic core_clk=0,rst=1,wrStrobe=0,stopClockInstruction=0,resetOvervoltage=0,irqAck,freqSelect,wdtIrqReq;
   logic busHoldGranted=0,dmaActive=0,refreshActive=0,swResetPulse,q[$];
   logic [7:0] wrAddr=0,wrData=0;
   logic [11:0] wdtCount,v;
   int err_count=0,cmp_count=0,cyc=0;
   wdt_timer uut(.*);
   wdt_cpu_model cpu(.core_clk,.rst,.irq(wdtIrqReq),.ack(irqAck));
   always #50 core_clk=~core_clk;
   task chk(string n,logic [11:0] s,e);
      cmp_count++;
      if (s!==e) begin err_count++; $display("CHECK FAILED %s %h %h",n,e,s); end
   endtask
   task close_out;
      $display("errors %0d of %0d",err_count,cmp_count);
      if (err_count==0&&cmp_count>0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task tk(int n); repeat(n) @(posedge core_clk); #1; endtask
   task wr(logic [7:0] a); wrAddr=a; wrData=8'($urandom)|8'h09; wrStrobe=1; tk(1); wrStrobe=0; endtask
   task frz(logic [2:0] m);
      {busHoldGranted,dmaActive,refreshActive}=m; tk(1); v=wdtCount;
      tk(100); chk("hold",wdtCount,v);
      {busHoldGranted,dmaActive,refreshActive}=0; tk(40);
   endtask
   always @(posedge core_clk) if (++cyc>90000) begin err_count++; close_out; end
   always @(posedge wdtIrqReq or posedge swResetPulse) #1 chk("ev",wdtIrqReq,q.pop_front());
   initial begin
      void'($urandom(33836));
      tk(8); rst=0;
      tk(600); chk("slow",wdtCount,12'hFFE);
      wr(8'h61); chk("fs",freqSelect,1);
      tk(300); frz(3'b100); frz(3'b010); frz(3'b001);
      resetOvervoltage=1; tk(3); chk("ovv",wdtCount,12'hFFF); resetOvervoltage=0;
      tk(100); stopClockInstruction=1; tk(1); stopClockInstruction=0; chk("stp",wdtCount,12'hFFF);
      tk(100); wr(8'h60); chk("kick",wdtCount,12'hFFF);
      q.push_back(0); tk(1); wr(8'h5E); tk(3); chk("swp",swResetPulse,1);
      tk(1); chk("swe",swResetPulse,0);
      q.push_back(1); @(posedge irqAck); tk(1); chk("ack",wdtIrqReq,0);
      close_out;
   end
endmodule
